/* File: hdl/purs_pkg.sv */
// Constants shared by the power-up reset sequencer
package purs_pkg;
    // Clock rates
    localparam int unsigned CLK_HZ          = 200000000;
    localparam int unsigned SLOW_OSC_HZ     = 1000000;
    localparam int unsigned FAST_OSC_HZ     = 50000000;
    localparam int unsigned SLOW_DIV        = CLK_HZ / SLOW_OSC_HZ;
    localparam int unsigned FAST_DIV        = CLK_HZ / FAST_OSC_HZ;
    // Power-on delay settings in microseconds
    localparam int unsigned DLY_50US_US     = 50;
    localparam int unsigned DLY_1MS_US      = 1000;
    localparam int unsigned DLY_10MS_US     = 10000;
    localparam int unsigned DLY_100MS_US    = 100000;
    // Delay select codes
    localparam logic [1:0]  DSEL_50US       = 2'h0;
    localparam logic [1:0]  DSEL_1MS        = 2'h1;
    localparam logic [1:0]  DSEL_10MS       = 2'h2;
    localparam logic [1:0]  DSEL_100MS      = 2'h3;
    // Slow-tick width of the delay counter
    localparam int unsigned DLY_W           = 17;
    // Period variability margin, percent
    localparam int unsigned VAR_PCT         = 10;
    // Settle time between steps in fast ticks
    localparam int unsigned STEP_TICKS      = 4;
    localparam int unsigned STEP_W          = 3;

    typedef enum logic [3:0] {
        PURS_ST_RAMP,
        PURS_ST_DELAY,
        PURS_ST_OSC_SWAP,
        PURS_ST_FABRIC_ON,
        PURS_ST_IBUF_ON,
        PURS_ST_FPOR_REL,
        PURS_ST_WAIT_CCC,
        PURS_ST_WAIT_SPLL,
        PURS_ST_M2F_REL,
        PURS_ST_OBUF_ON,
        PURS_ST_RUN
    } purs_state_e;
endpackage

/* File: hdl/purs_sync.sv */
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/10ps
module purs_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    input  wire logic async_i,
    output logic      sync_o
);
    logic meta_ff;
    logic sync_ff;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;
endmodule // purs_sync

/* File: hdl/purs_sequencer.sv */
// Power-up to functional reset sequencer
// Operation
// - Assert internal power-on reset at power-up
// - Fabric sees reset only after supply check
// - Slow oscillator clocks delay counter during reset
// - Release internal reset at terminal count
// - Gate slow oscillator, enable fast oscillator
// - Power fabric RAMs, fabric_block_a, DDR, transceivers
// - Enable input buffers before fabric reset release
// - Then release fabric power-on reset
// - Fabric PLL lock precedes subsystem PLL lock
// - Release subsystem-to-fabric reset after subsystem lock
// - Output buffer enable is final step
// - Terminal count from setting, frequency, variability
// - Accept power-on, system and block requests
// - Delay settings 50us, 1ms, 10ms, 100ms
// - Delay counter runs only on power-up
// - Fabric reset low on power-up, pin, program, zeroize
`timescale 1ns/10ps
module purs_sequencer #(
    parameter int unsigned SLOW_DIV = purs_pkg::SLOW_DIV,
    parameter int unsigned FAST_DIV = purs_pkg::FAST_DIV,
    parameter int unsigned VAR_PCT  = purs_pkg::VAR_PCT,
    parameter int unsigned NBLK     = 4
) (
    input  wire logic            ref_clk_i,
    input  wire logic            rst_i,
    input  wire logic            supply_ok_i,
    input  wire logic [1:0]      delay_sel_i,
    input  wire logic            device_reset_pin_n_i,
    input  wire logic            prog_done_i,
    input  wire logic            zeroize_done_i,
    input  wire logic            sc_sys_reset_req_i,
    input  wire logic            fabric_sys_reset_req_i,
    input  wire logic [NBLK-1:0] fabric_blk_reset_req_i,
    input  wire logic [NBLK-1:0] system_register_block_blk_reset_req_i,
    input  wire logic            ccc_lock_i,
    input  wire logic            subsystem_pll_lock_i,
    output logic                 internal_por_n_o,
    output logic                 slow_osc_en_o,
    output logic                 fast_osc_en_o,
    output logic                 fabric_power_en_o,
    output logic                 ibuf_en_o,
    output logic                 fabric_por_n_o,
    output logic                 subsystem_to_fabric_reset_n_o,
    output logic                 obuf_en_o,
    output logic                 sys_reset_n_o,
    output logic [NBLK-1:0]      blk_reset_n_o,
    output logic                 lock_order_err_o
);
    // =========================================================
    // Elaboration checks
    if (SLOW_DIV < 2 || FAST_DIV < 1 || SLOW_DIV <= FAST_DIV || VAR_PCT > 50) begin : g_bad_div
        $error("purs_sequencer: unsupported divider or margin");
    end
    if (NBLK < 1) begin : g_bad_nblk
        $error("purs_sequencer: NBLK must be at least one");
    end

    // =========================================================
    // Input synchronisers
    localparam int unsigned NSYNC = 8;
    logic [NSYNC-1:0] async_v;
    logic [NSYNC-1:0] sync_v;
    logic [NBLK-1:0]  fblk_s;
    logic [NBLK-1:0]  sblk_s;
    logic supply_s, pin_n_s, prog_s, zero_s, scsys_s, fsys_s, ccc_s, spll_s;

    assign async_v = {supply_ok_i, device_reset_pin_n_i, prog_done_i, zeroize_done_i,
                      sc_sys_reset_req_i, fabric_sys_reset_req_i, ccc_lock_i,
                      subsystem_pll_lock_i};
    assign {supply_s, pin_n_s, prog_s, zero_s, scsys_s, fsys_s, ccc_s, spll_s} = sync_v;

    for (genvar g = 0; g < NSYNC; g++) begin : g_sync
        purs_sync #(.RST_VAL((g == 6) ? 1'b1 : 1'b0)) u_sync (
            .ref_clk_i (ref_clk_i),
            .rst_i     (rst_i),
            .async_i   (async_v[g]),
            .sync_o    (sync_v[g])
        );
    end
    for (genvar b = 0; b < NBLK; b++) begin : g_blk
        purs_sync u_fb (
            .ref_clk_i (ref_clk_i),
            .rst_i     (rst_i),
            .async_i   (fabric_blk_reset_req_i[b]),
            .sync_o    (fblk_s[b])
        );
        purs_sync u_sb (
            .ref_clk_i (ref_clk_i),
            .rst_i     (rst_i),
            .async_i   (system_register_block_blk_reset_req_i[b]),
            .sync_o    (sblk_s[b])
        );
    end

    // =========================================================
    // Oscillator ticks
    localparam int unsigned DIV_W = $clog2(SLOW_DIV + 1);
    logic [DIV_W-1:0] div_ff;
    logic             tick;
    logic             slow_run;

    assign slow_run = slow_osc_en_o;
    assign tick = (div_ff == DIV_W'(0));

    // Active oscillator pace; slow while the delay counter runs
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || tick)
            div_ff <= slow_run ? DIV_W'(SLOW_DIV - 1) : DIV_W'(FAST_DIV - 1);
        else
            div_ff <= div_ff - DIV_W'(1);
    end

    // =========================================================
    // Terminal count: nominal ticks plus variability margin
    function automatic logic [purs_pkg::DLY_W-1:0] term_cnt(input logic [1:0] sel);
        int unsigned us;
        us = purs_pkg::DLY_100MS_US;
        case (sel)
            purs_pkg::DSEL_50US: us = purs_pkg::DLY_50US_US;
            purs_pkg::DSEL_1MS:  us = purs_pkg::DLY_1MS_US;
            purs_pkg::DSEL_10MS: us = purs_pkg::DLY_10MS_US;
            default:             us = purs_pkg::DLY_100MS_US;
        endcase
        return purs_pkg::DLY_W'(us + (us * VAR_PCT + 99) / 100);
    endfunction

    // Setting caught when the supply check passes, not at reset
    logic [1:0] dsel_ff;
    logic [purs_pkg::DLY_W-1:0] dly_ff;
    logic [purs_pkg::STEP_W-1:0] step_ff;
    purs_pkg::purs_state_e st_ff;
    logic step_done;
    logic [3:0] st_q_ff;

    // Count left over from a waiting state must not end the next step early
    assign step_done = tick && (st_q_ff == 4'(st_ff)) &&
                       (step_ff == purs_pkg::STEP_W'(purs_pkg::STEP_TICKS - 1));

    // =========================================================
    // Sequence state machine
    // A cold power-on is rst_i; the reset pin and programming events never
    // re-enter the delay state, they only pull the fabric resets and output buffer enable.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_ff <= purs_pkg::PURS_ST_RAMP;
        end else begin
            case (st_ff)
                purs_pkg::PURS_ST_RAMP:
                    if (supply_s)
                        st_ff <= purs_pkg::PURS_ST_DELAY;
                purs_pkg::PURS_ST_DELAY:
                    if (tick && dly_ff == term_cnt(dsel_ff))
                        st_ff <= purs_pkg::PURS_ST_OSC_SWAP;
                purs_pkg::PURS_ST_OSC_SWAP:
                    if (step_done)
                        st_ff <= purs_pkg::PURS_ST_FABRIC_ON;
                purs_pkg::PURS_ST_FABRIC_ON:
                    if (step_done)
                        st_ff <= purs_pkg::PURS_ST_IBUF_ON;
                purs_pkg::PURS_ST_IBUF_ON:
                    if (step_done)
                        st_ff <= purs_pkg::PURS_ST_FPOR_REL;
                purs_pkg::PURS_ST_FPOR_REL:
                    if (step_done)
                        st_ff <= purs_pkg::PURS_ST_WAIT_CCC;
                purs_pkg::PURS_ST_WAIT_CCC:
                    if (ccc_s && tick)
                        st_ff <= purs_pkg::PURS_ST_WAIT_SPLL;
                purs_pkg::PURS_ST_WAIT_SPLL:
                    if (spll_s && tick)
                        st_ff <= purs_pkg::PURS_ST_M2F_REL;
                purs_pkg::PURS_ST_M2F_REL:
                    if (step_done)
                        st_ff <= purs_pkg::PURS_ST_OBUF_ON;
                purs_pkg::PURS_ST_OBUF_ON:
                    st_ff <= purs_pkg::PURS_ST_RUN;
                purs_pkg::PURS_ST_RUN:
                    st_ff <= purs_pkg::PURS_ST_RUN;
                default:
                    st_ff <= purs_pkg::PURS_ST_RAMP;
            endcase
        end
    end

    // Delay counter, running only in the power-up delay state
    always_ff @(posedge ref_clk_i) begin
        if (rst_i)
            dly_ff <= '0;
        else if (st_ff == purs_pkg::PURS_ST_DELAY && tick)
            dly_ff <= dly_ff + purs_pkg::DLY_W'(1);
        else if (st_ff != purs_pkg::PURS_ST_DELAY)
            dly_ff <= '0;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i)
            dsel_ff <= purs_pkg::DSEL_100MS;
        else if (st_ff == purs_pkg::PURS_ST_RAMP)
            dsel_ff <= delay_sel_i;
    end

    // Settle counter between fast-clock steps
    always_ff @(posedge ref_clk_i) begin
        if (rst_i)
            st_q_ff <= 4'h0;
        else
            st_q_ff <= 4'(st_ff);
    end
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || st_q_ff != 4'(st_ff))
            step_ff <= '0;
        else if (tick)
            step_ff <= step_ff + purs_pkg::STEP_W'(1);
    end

    // =========================================================
    // Sequenced outputs, all updated every reference clock, not only on the oscillator tick
    logic post_por;
    logic fpor_cause;
    assign post_por   = (st_ff >= purs_pkg::PURS_ST_OSC_SWAP);
    assign fpor_cause = !pin_n_s || prog_s || zero_s;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            internal_por_n_o  <= 1'b0;
            slow_osc_en_o     <= 1'b0;
            fast_osc_en_o     <= 1'b0;
            fabric_power_en_o <= 1'b0;
            ibuf_en_o         <= 1'b0;
            obuf_en_o         <= 1'b0;
        end else begin
            internal_por_n_o  <= post_por;
            slow_osc_en_o     <= (st_ff == purs_pkg::PURS_ST_DELAY) ||
                                 (st_ff == purs_pkg::PURS_ST_RAMP && supply_s);
            fast_osc_en_o     <= post_por;
            fabric_power_en_o <= (st_ff >= purs_pkg::PURS_ST_FABRIC_ON);
            ibuf_en_o         <= (st_ff >= purs_pkg::PURS_ST_IBUF_ON);
            obuf_en_o         <= (st_ff >= purs_pkg::PURS_ST_OBUF_ON) && !fpor_cause;
        end
    end

    // Resets deassert only on a tick of the running oscillator
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            fabric_por_n_o                <= 1'b0;
            subsystem_to_fabric_reset_n_o <= 1'b0;
        end else begin
            if (fpor_cause || st_ff < purs_pkg::PURS_ST_FPOR_REL)
                fabric_por_n_o <= 1'b0;
            else if (tick)
                fabric_por_n_o <= 1'b1;
            if (fpor_cause || st_ff < purs_pkg::PURS_ST_M2F_REL || !sys_reset_n_o)
                subsystem_to_fabric_reset_n_o <= 1'b0;
            else if (tick)
                subsystem_to_fabric_reset_n_o <= 1'b1;
        end
    end

    // =========================================================
    // Reset request classes
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sys_reset_n_o <= 1'b0;
            blk_reset_n_o <= '0;
        end else begin
            sys_reset_n_o <= post_por && !scsys_s && !fsys_s;
            blk_reset_n_o <= (post_por && !scsys_s && !fsys_s) ?
                             ~(fblk_s | sblk_s) : '0;
        end
    end

    // Subsystem lock seen while fabric lock is missing
    always_ff @(posedge ref_clk_i) begin
        if (rst_i)
            lock_order_err_o <= 1'b0;
        else if (st_ff == purs_pkg::PURS_ST_WAIT_CCC && spll_s && !ccc_s)
            lock_order_err_o <= 1'b1;
    end

    // =========================================================
    // Checks
    AST_POR_AT_START: assert property (@(posedge ref_clk_i) $rose(rst_i) |=> !internal_por_n_o)
        else $error("internal reset not low after power-on");
    AST_OSC_EXCL: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !(slow_osc_en_o && fast_osc_en_o))
        else $error("both oscillators enabled");
    AST_IBUF_FIRST: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(fabric_por_n_o) |-> ibuf_en_o && fabric_power_en_o)
        else $error("fabric reset released before input buffers");
    AST_FPOR_AFTER_POR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        fabric_por_n_o |-> internal_por_n_o && fast_osc_en_o)
        else $error("fabric reset released too early");
    AST_M2F_AFTER_LOCK: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(subsystem_to_fabric_reset_n_o) |-> fabric_por_n_o && $past(spll_s, 2))
        else $error("subsystem reset released without lock");
    AST_OBUF_LAST: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(obuf_en_o) |-> $past(st_ff) >= purs_pkg::PURS_ST_OBUF_ON)
        else $error("output buffers enabled early");
    AST_PIN_FPOR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        fpor_cause |=> !fabric_por_n_o)
        else $error("fabric reset not asserted by reset event");
    AST_DLY_IDLE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        st_ff != purs_pkg::PURS_ST_DELAY |=> dly_ff == '0)
        else $error("delay counter runs outside power-up");
    AST_SYS_REQ: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        fsys_s |=> !sys_reset_n_o ##1 !subsystem_to_fabric_reset_n_o)
        else $error("system reset request ignored");
endmodule // purs_sequencer

/* File: tb/purs_fabric_model.sv */
// Behavioural model of the user fabric logic beside the sequencer
`timescale 1ns/10ps
module purs_fabric_model (
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    input  wire logic fabric_por_n_i,
    input  wire logic subsystem_to_fabric_reset_n_i,
    input  wire logic bad_order_i,
    output logic      fabric_pll_lock_o,
    output logic      subsystem_pll_lock_o,
    output logic      fabric_reset_n_o
);
    logic [5:0] lock_cnt_ff;

    // ==========================================================
    // Lock timing
    // PLLs keep their lock once gained; only a power-up clears it
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            lock_cnt_ff <= 6'h00;
        end else if (fabric_por_n_i && lock_cnt_ff != 6'h3F) begin
            lock_cnt_ff <= lock_cnt_ff + 6'h01;
        end
    end
    // Wrong order only when the bench asks for it
    assign fabric_pll_lock_o    = lock_cnt_ff >= (bad_order_i ? 6'h1E : 6'h14);
    assign subsystem_pll_lock_o = lock_cnt_ff >= (bad_order_i ? 6'h0A : 6'h28);

    // ==========================================================
    // Fabric reset
    assign fabric_reset_n_o = fabric_por_n_i & subsystem_to_fabric_reset_n_i;
endmodule // purs_fabric_model

/* File: tb/tb.sv */
// Self-checking bench for the power-up reset sequencer
`timescale 1ns/10ps
module tb;
    localparam int unsigned SDIV = 4;
    logic       ref_clk_i, rst_i, supply_ok, pin_n, prog, zero, sc_req, fab_req, bad_order;
    logic       pll_a, spll, ipor, slow, fast, fpw, ibuf, fpor, s2f, obuf, sys_n, err, fab_n;
    logic [1:0] sel;
    logic [3:0] fblk, sblk, blk_n;
    logic [6:0] st;
    int         num_errors, check_count;

    assign st = {obuf, s2f, fpor, ibuf, fpw, fast, ipor};

    // ==========================================================
    // Design and fabric model
    purs_sequencer #(.SLOW_DIV(SDIV), .FAST_DIV(1), .VAR_PCT(10), .NBLK(4)) purs_sequencer_inst (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .supply_ok_i(supply_ok), .delay_sel_i(sel),
        .device_reset_pin_n_i(pin_n), .prog_done_i(prog), .zeroize_done_i(zero),
        .sc_sys_reset_req_i(sc_req), .fabric_sys_reset_req_i(fab_req),
        .fabric_blk_reset_req_i(fblk), .system_register_block_blk_reset_req_i(sblk),
        .ccc_lock_i(pll_a), .subsystem_pll_lock_i(spll), .internal_por_n_o(ipor),
        .slow_osc_en_o(slow), .fast_osc_en_o(fast), .fabric_power_en_o(fpw), .ibuf_en_o(ibuf),
        .fabric_por_n_o(fpor), .subsystem_to_fabric_reset_n_o(s2f), .obuf_en_o(obuf),
        .sys_reset_n_o(sys_n), .blk_reset_n_o(blk_n), .lock_order_err_o(err));
    purs_fabric_model purs_fabric_model_inst (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .fabric_por_n_i(fpor),
        .subsystem_to_fabric_reset_n_i(s2f), .bad_order_i(bad_order),
        .fabric_pll_lock_o(pll_a), .subsystem_pll_lock_o(spll), .fabric_reset_n_o(fab_n));

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic wait_bit(input int idx, input int lim, output int cnt);
        cnt = 0;
        while (st[idx] !== 1'b1 && cnt < lim) begin
            tick(1);
            cnt++;
        end
    endtask
    task automatic power_up(input logic [1:0] s, input logic bad);
        rst_i = 1'b1;
        supply_ok = 1'b0;
        sel = s;
        bad_order = bad;
        tick(5);
        chk({slow, st}, 8'h00);
        rst_i = 1'b0;
        tick(20);
        chk({slow, st}, 8'h00);
        supply_ok = 1'b1;
        tick(8);
        chk({slow, ipor}, 2'h2);
    endtask

    // ==========================================================
    // Scenarios
    // Whole walk; late changes the setting once the delay runs
    task automatic t_full(input logic [1:0] s, input int us, input logic late, input logic bad);
        int term;
        int cnt;
        term = us + (us * 10 + 99) / 100;
        power_up(s, bad);
        if (late) sel = ~s;
        wait_bit(0, term * SDIV + 60, cnt);
        chk(cnt + 8 >= term * SDIV, 1);
        chk(cnt + 8 <= term * SDIV + 2 * SDIV + 12, 1);
        tick(2);
        chk({slow, fast}, 2'h1);
        for (int i = 2; i < 7; i++) begin
            wait_bit(i, 200, cnt);
            chk(st, 7'h7F >> (6 - i));
            if (i == 5) chk(spll & pll_a, 1);
        end
        chk({err, sys_n, blk_n, fab_n}, {bad, 6'h3F});
        $display("full sequence test done, %0d us", us);
    endtask
    // Pin, programming and zeroize events pull only the fabric side
    task automatic t_events();
        for (int e = 0; e < 3; e++) begin
            {pin_n, prog, zero} = (e == 0) ? 3'h0 : ((e == 1) ? 3'h6 : 3'h5);
            tick(6);
            chk({ipor, slow, fpor, s2f, obuf, fab_n}, 6'h20);
            {pin_n, prog, zero} = 3'h4;
            tick(SDIV * 4 + 60);
            chk({ipor, slow, fpor, s2f, obuf, fab_n}, 6'h2F);
        end
        $display("reset event test done");
    endtask
    // System requests from both sources, then each block request
    task automatic t_requests();
        for (int r = 0; r < 10; r++) begin
            {sc_req, fab_req} = (r == 0) ? 2'h2 : ((r == 1) ? 2'h1 : 2'h0);
            fblk = (r >= 2 && r < 6) ? 4'h1 << (r - 2) : 4'h0;
            sblk = (r >= 6) ? 4'h1 << (r - 6) : 4'h0;
            tick(8);
            chk({sys_n, blk_n}, (r < 2) ? 5'h00 : {1'b1, ~(fblk | sblk)});
            if (r < 2) chk(s2f, 1'b0);
            {sc_req, fab_req, fblk, sblk} = 10'h000;
            tick(60);
            chk({sys_n, blk_n, s2f}, 6'h3F);
        end
        $display("reset request test done");
    endtask
    // Long settings still hold the reset past the 1 ms count
    task automatic t_long(input logic [1:0] s);
        power_up(s, 1'b0);
        tick(1100 * SDIV + 100);
        chk({slow, ipor}, 2'h2);
        $display("long delay test done, setting %0h", s);
    endtask

    // ==========================================================
    // Clock, run and verdict
    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        {rst_i, supply_ok, pin_n, prog, zero, sc_req, fab_req, bad_order} = 8'hA0;
        {sel, fblk, sblk} = 10'h000;
        num_errors = 0;
        check_count = 0;
        t_full(purs_pkg::DSEL_50US, 50, 1'b0, 1'b0);
        t_events();
        t_requests();
        t_full(purs_pkg::DSEL_1MS, 1000, 1'b1, 1'b0);
        t_long(purs_pkg::DSEL_10MS);
        t_long(purs_pkg::DSEL_100MS);
        t_full(purs_pkg::DSEL_50US, 50, 1'b0, 1'b1);
        close_out();
    end
    // Run needs about 15000 clocks; allow four times that
    initial begin
        #300000;
        num_errors++;
        close_out();
    end
endmodule // tb
